// >>> pmwc_pkg.sv
/*
 * pmwc_pkg: offsets, field positions, reset values, time constants and the
 * sequencer state type of the power-mode and wake control block.
 * assumes a 100 MHz system clock and an 8-bit byte-addressed register port.
 */
package pmwc_pkg;
    // register byte offsets
    localparam logic [7:0]  PMC_OFFSET    = 8'h84;
    localparam logic [7:0]  TEST_OFFSET   = 8'h64;
    // test register read value, arbitrary
    localparam logic [31:0] TEST_PATTERN  = 32'h5a3c_c3a5;

    // field positions in power_mgmt_control
    localparam int PM_LO        = 12;
    localparam int TRANSCEIVER_RESET_BIT  = 10;
    localparam int LAN_EN_BIT   = 9;
    localparam int ENERGY_DETECT_ENABLE_BIT    = 8;
    localparam int DRIVE_BIT    = 6;
    localparam int CAUSE_LO     = 4;
    localparam int PULSE_BIT    = 3;
    localparam int POL_BIT      = 2;
    localparam int OUT_EN_BIT   = 1;
    localparam int READY_BIT    = 0;

    // index of each cause inside the two-bit wake_cause_status field
    localparam int CAUSE_ENERGY = 0;
    localparam int CAUSE_FRAME  = 1;

    // power_state_sel encodings
    localparam logic [1:0] PM_NORMAL = 2'h0;
    localparam logic [1:0] PM_FRAME  = 2'h1;
    localparam logic [1:0] PM_ENERGY = 2'h2;
    localparam logic [1:0] PM_RESV   = 2'h3;

    // values after reset
    localparam logic [1:0] PM_RESET    = 2'h0;
    localparam logic [1:0] CAUSE_RESET = 2'h0;
    localparam logic       CTRL_RESET  = 1'h0;

    // timing
    localparam int CLK_MHZ     = 100;
    localparam int TRANSCEIVER_RESET_US  = 100;
    localparam int TRANSCEIVER_RESET_CYC = TRANSCEIVER_RESET_US * CLK_MHZ;
    localparam int PULSE_MS    = 50;
    localparam int PULSE_CYC   = PULSE_MS * 1000 * CLK_MHZ;
    localparam int SETTLE_CYC  = 16;

    typedef enum logic [1:0] {
        SEQ_RUN    = 2'b00,
        SEQ_SLEEP  = 2'b01,
        SEQ_SETTLE = 2'b10
    } pmwc_seq_e;
endpackage

// >>> pmwc_wake_if.sv
/*
 * pmwc_wake_if: request and configuration from the control core to the
 * wake output driver.
 * assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
interface pmwc_wake_if;
    logic assertReq;
    logic pushPull;
    logic activeHigh;
    modport src  (output assertReq, output pushPull, output activeHigh);
    modport sink (input assertReq, input pushPull, input activeHigh);
endinterface

// >>> pmwc_timer.sv
/*
 * pmwc_timer: retriggerable one-shot, busy for exactly CYCLES clock cycles
 * from the edge after start.
 * assumes a synchronous start pulse and an already synchronised reset.
 */
`timescale 1ns/1ps
module pmwc_timer #(
    parameter int unsigned CYCLES = 16
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rstN,
    // control
    input  wire logic start,
    output logic      busy
);
    localparam int W = $clog2(CYCLES + 1);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (start) begin
            cnt_d = W'(CYCLES);
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign busy = (cnt_q != '0);
endmodule // pmwc_timer

// >>> pmwc_wake_out.sv
/*
 * pmwc_wake_out: registered pad driver for the wake output pin.
 * assumes the pad wire is resolved outside from level and enable.
 */
`timescale 1ns/1ps
module pmwc_wake_out (
    // clock and reset
    input  wire logic  clk,
    input  wire logic  rstN,
    // request from the control core
    pmwc_wake_if.sink  req,
    // pad
    output logic       pinOut,
    output logic       pinOe
);
    logic out_d;
    logic oe_d;

    always_comb begin
        if (req.pushPull) begin
            oe_d  = 1'b1;
            out_d = req.activeHigh ? req.assertReq : ~req.assertReq;
        end else begin
            // wired-or: pull low only while asserted, polarity has no say
            oe_d  = req.assertReq;
            out_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pinOut <= 1'b0;
            pinOe  <= 1'b0;
        end else begin
            pinOut <= out_d;
            pinOe  <= oe_d;
        end
    end
endmodule // pmwc_wake_out

// >>> pmwc_power_ctrl.sv
/*
 * pmwc_power_ctrl: power-mode sequencer, transceiver reset timer, wake
 * cause status and wake output control, with its register port.
 * assumes a master that pulses one strobe per cycle and synchronous event
 * inputs held high until their source is cleared.
 */
// Added by the designer: strobed register access.
`timescale 1ns/1ps
// Contract
// - state field: 00 normal, 01 frame, 10 energy
// - test register write wakes from low power
// - control register readable in any power state
// - writes ignored until a read after wake
// - transceiver reset bit holds reset 100us
// - reset bit clears when transceiver released
// - reset bit writes ignored while high
// - lan wake event drives enabled wake output
// - lan wake event raises wake interrupt
// - energy event drives enabled wake output
// - energy event raises wake interrupt
// - drive type: 0 open-drain, 1 push-pull
// - open-drain output always active low
// - cause field reports energy, frame, both
// - cause bits clear on write one
// - cause clears only when running and ready
// - indication bit chooses pulse or static output
// - pulse lasts 50ms, static holds continuously
// - push-pull polarity bit: 1 high, 0 low
// - output enable gates pin, not interrupt
// - ready bit shows device fully awake
module pmwc_power_ctrl import pmwc_pkg::*; #(
    parameter int unsigned TRANSCEIVER_RESET_CYCLES = TRANSCEIVER_RESET_CYC,
    parameter int unsigned PULSE_CYCLES   = PULSE_CYC
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWrEn,
    input  wire logic        regRdEn,
    output logic      [31:0] regRdData,
    // wake event sources
    input  wire logic        lanWakeEvt,
    input  wire logic        energyEvt,
    // status and control outputs
    output logic      [1:0]  powerState,
    output logic             deviceReady,
    output logic             wakeInterrupt,
    output logic             transceiverResetN,
    // wake pin
    output logic             wakeOut,
    output logic             wakeOutOe
);
    // address compare shared by read decode, write qualify and wake detect
    function automatic logic hits(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    logic       rstMeta_q;
    logic       rstN;
    pmwc_seq_e  seq_q, seq_d;
    logic [1:0] pmState_q, pmState_d;
    logic       ready_q, ready_d;
    logic       readSeen_q, readSeen_d;
    logic       lanEn_q, lanEn_d;
    logic       edEn_q, edEn_d;
    logic       pushPull_q, pushPull_d;
    logic       pulseMode_q, pulseMode_d;
    logic       polHigh_q, polHigh_d;
    logic       outEn_q, outEn_d;
    logic [1:0] cause_q, cause_d;
    logic       hitPrev_q, hitPrev_d;
    logic       intr_q, intr_d;
    logic       phyRstN_q, phyRstN_d;
    logic       assert_q, assert_d;
    logic [31:0] rdData_q, rdData_d;
    logic [31:0] pmcWord;
    logic [1:0] evt;
    logic [1:0] causeEn;
    logic       wrOk;
    logic       pmcWr;
    logic       evtHit;
    logic       phyStart;
    logic       pulseStart;
    logic       settleStart;
    logic       phyBusy;
    logic       pulseBusy;
    logic       settleBusy;

    // reset release through two flops, assertion stays asynchronous
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rstMeta_q <= 1'b0;
            rstN      <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstN      <= rstMeta_q;
        end
    end

    // transceiver reset span; busy doubles as the self-clearing reset bit
    pmwc_timer #(.CYCLES(TRANSCEIVER_RESET_CYCLES)) uPhyTimer (
        .clk   (sys_clk),
        .rstN  (rstN),
        .start (phyStart),
        .busy  (phyBusy)
    );

    // indication pulse width; a fresh event restarts it
    pmwc_timer #(.CYCLES(PULSE_CYCLES)) uPulseTimer (
        .clk   (sys_clk),
        .rstN  (rstN),
        .start (pulseStart),
        .busy  (pulseBusy)
    );

    // stands in for clock settling between the wake write and ready
    pmwc_timer #(.CYCLES(SETTLE_CYC)) uSettleTimer (
        .clk   (sys_clk),
        .rstN  (rstN),
        .start (settleStart),
        .busy  (settleBusy)
    );

    assign evt[CAUSE_ENERGY]     = energyEvt;
    assign evt[CAUSE_FRAME]      = lanWakeEvt;
    assign causeEn[CAUSE_ENERGY] = edEn_q;
    assign causeEn[CAUSE_FRAME]  = lanEn_q;

    always_comb begin
        pmcWord                         = '0;
        pmcWord[PM_LO +: 2]             = pmState_q;
        pmcWord[TRANSCEIVER_RESET_BIT]            = phyBusy;
        pmcWord[LAN_EN_BIT]             = lanEn_q;
        pmcWord[ENERGY_DETECT_ENABLE_BIT]              = edEn_q;
        pmcWord[DRIVE_BIT]              = pushPull_q;
        pmcWord[CAUSE_LO +: 2]          = cause_q;
        pmcWord[PULSE_BIT]              = pulseMode_q;
        pmcWord[POL_BIT]                = polHigh_q;
        pmcWord[OUT_EN_BIT]             = outEn_q;
        pmcWord[READY_BIT]              = ready_q;
    end

    // host writes count only after a read and while awake
    assign wrOk  = regWrEn && readSeen_q && ready_q;
    assign pmcWr = wrOk && hits(regAddr, PMC_OFFSET);
    assign evtHit = |(evt & causeEn);

    always_comb begin
        seq_d       = seq_q;
        pmState_d   = pmState_q;
        ready_d     = ready_q;
        readSeen_d  = readSeen_q | regRdEn;
        lanEn_d     = lanEn_q;
        edEn_d      = edEn_q;
        pushPull_d  = pushPull_q;
        pulseMode_d = pulseMode_q;
        polHigh_d   = polHigh_q;
        outEn_d     = outEn_q;
        cause_d     = cause_q;
        hitPrev_d   = evtHit;
        phyStart    = 1'b0;
        settleStart = 1'b0;
        rdData_d    = '0;

        // read data stands one cycle and is zero otherwise
        if (regRdEn) begin
            if (hits(regAddr, PMC_OFFSET)) begin
                rdData_d = pmcWord;
            end else if (hits(regAddr, TEST_OFFSET)) begin
                rdData_d = TEST_PATTERN;
            end
        end

        if (pmcWr) begin
            lanEn_d     = regWrData[LAN_EN_BIT];
            edEn_d      = regWrData[ENERGY_DETECT_ENABLE_BIT];
            pushPull_d  = regWrData[DRIVE_BIT];
            pulseMode_d = regWrData[PULSE_BIT];
            polHigh_d   = regWrData[POL_BIT];
            outEn_d     = regWrData[OUT_EN_BIT];
            if (regWrData[TRANSCEIVER_RESET_BIT] && !phyBusy) begin
                phyStart = 1'b1;
            end
        end

        // clear first so a same-cycle event sets the bit again
        for (int i = 0; i < 2; i++) begin
            if (pmcWr && seq_q == SEQ_RUN && regWrData[CAUSE_LO + i]) begin
                cause_d[i] = 1'b0;
            end
            if (evt[i] && causeEn[i]) begin
                cause_d[i] = 1'b1;
            end
        end

        case (seq_q)
            SEQ_RUN: begin
                if (pmcWr && (regWrData[PM_LO +: 2] == PM_FRAME ||
                              regWrData[PM_LO +: 2] == PM_ENERGY)) begin
                    // reserved encoding is left alone
                    pmState_d = regWrData[PM_LO +: 2];
                    ready_d   = 1'b0;
                    seq_d     = SEQ_SLEEP;
                end
            end
            SEQ_SLEEP: begin
                // the wake write bypasses the ready and read-seen gating
                if (regWrEn && hits(regAddr, TEST_OFFSET)) begin
                    settleStart = 1'b1;
                    seq_d       = SEQ_SETTLE;
                end
            end
            SEQ_SETTLE: begin
                if (!settleBusy) begin
                    pmState_d  = PM_NORMAL;
                    ready_d    = 1'b1;
                    readSeen_d = 1'b0;
                    seq_d      = SEQ_RUN;
                end
            end
            default: begin
                seq_d = SEQ_RUN;
            end
        endcase

        intr_d = |(cause_d & causeEn);
        // pulsed mode also drops when the cause or its enable goes away
        // the pulsed request starts a cycle after the static one, once the timer runs
        if (pulseMode_q) begin
            assert_d = outEn_q && pulseBusy && intr_d;
        end else begin
            assert_d = outEn_q && intr_d;
        end
        phyRstN_d = ~phyBusy;
    end

    // a fresh qualifying event starts a new pulse
    assign pulseStart = evtHit && !hitPrev_q && pulseMode_q;

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            seq_q       <= SEQ_RUN;
            pmState_q   <= PM_RESET;
            ready_q     <= 1'b1;
            readSeen_q  <= 1'b0;
            lanEn_q     <= CTRL_RESET;
            edEn_q      <= CTRL_RESET;
            pushPull_q  <= CTRL_RESET;
            pulseMode_q <= CTRL_RESET;
            polHigh_q   <= CTRL_RESET;
            outEn_q     <= CTRL_RESET;
            cause_q     <= CAUSE_RESET;
            hitPrev_q   <= 1'b0;
            intr_q      <= 1'b0;
            phyRstN_q   <= 1'b0;
            assert_q    <= 1'b0;
            rdData_q    <= '0;
        end else begin
            seq_q       <= seq_d;
            pmState_q   <= pmState_d;
            ready_q     <= ready_d;
            readSeen_q  <= readSeen_d;
            lanEn_q     <= lanEn_d;
            edEn_q      <= edEn_d;
            pushPull_q  <= pushPull_d;
            pulseMode_q <= pulseMode_d;
            polHigh_q   <= polHigh_d;
            outEn_q     <= outEn_d;
            cause_q     <= cause_d;
            hitPrev_q   <= hitPrev_d;
            intr_q      <= intr_d;
            phyRstN_q   <= phyRstN_d;
            assert_q    <= assert_d;
            rdData_q    <= rdData_d;
        end
    end

    // the pad driver registers the request, so the pin lags it by a cycle
    pmwc_wake_if wakeReq ();
    assign wakeReq.assertReq  = assert_q;
    assign wakeReq.pushPull   = pushPull_q;
    assign wakeReq.activeHigh = polHigh_q;

    pmwc_wake_out uWakeOut (
        .clk    (sys_clk),
        .rstN   (rstN),
        .req    (wakeReq),
        .pinOut (wakeOut),
        .pinOe  (wakeOutOe)
    );

    assign regRdData         = rdData_q;
    assign powerState        = pmState_q;
    assign deviceReady       = ready_q;
    assign wakeInterrupt     = intr_q;
    assign transceiverResetN = phyRstN_q;
endmodule // pmwc_power_ctrl

// >>> pmwc_host.sv
/* pmwc_host: host model that issues register cycles and notes expected reads.
   assumes one system clock; the bench monitor pops the notes. */
`timescale 1ns/1ps
module pmwc_host import pmwc_pkg::*; (
    // clock and status
    input  wire logic        clk,
    input  wire logic        ready,
    // register port
    output logic      [7:0]  addr,
    output logic      [31:0] wrData,
    output logic             wrEn,
    output logic             rdEn
);
    logic [31:0] expQ[$];
    logic [31:0] mskQ[$];
    initial begin
        addr = 8'h00;
        wrData = 32'h0;
        wrEn = 1'b0;
        rdEn = 1'b0;
    end
    // callers never pass 2'h3 in the state field
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrEn <= 1'b1;
        @(posedge clk);
        wrEn <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge clk);
        expQ.push_back(e);
        mskQ.push_back(m);
        addr <= a;
        rdEn <= 1'b1;
        @(posedge clk);
        rdEn <= 1'b0;
    endtask
    // only the test register is touched until ready, then a read re-arms writes
    task automatic wake(output bit ok);
        int n;
        wr(TEST_OFFSET, $urandom);
        n = 0;
        while (ready !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        ok = (n < 40);
        rd(PMC_OFFSET, 32'h1, 32'h3001);
    endtask
endmodule // pmwc_host

// >>> pmwc_power_ctrl_asserts.sv
/* pmwc_power_ctrl_asserts: port-level checks of the power-mode block.
   assumes the bind below hands on the reset count. */
`timescale 1ns/1ps
module pmwc_power_ctrl_asserts import pmwc_pkg::*; #(
    parameter int unsigned TRANSCEIVER_RESET_CYCLES = TRANSCEIVER_RESET_CYC
) (
    // clock and bus
    input wire logic        sys_clk,
    input wire logic        resetn,
    input wire logic [7:0]  regAddr,
    input wire logic [31:0] regWrData,
    input wire logic        regWrEn,
    input wire logic        regRdEn,
    input wire logic [31:0] regRdData,
    // events and status
    input wire logic        lanWakeEvt,
    input wire logic        energyEvt,
    input wire logic [1:0]  powerState,
    input wire logic        deviceReady,
    input wire logic        wakeInterrupt,
    input wire logic        transceiverResetN
);
    logic [15:0] lowCnt_q;
    logic        wasHigh_q;
    wire         rstWr  = regWrEn && regAddr == PMC_OFFSET && regWrData[TRANSCEIVER_RESET_BIT];
    wire         wakeWr = regWrEn && regAddr == TEST_OFFSET;
    // the first release after reset is not a timed pulse, so it is skipped
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            lowCnt_q <= 16'h0;
            wasHigh_q <= 1'b0;
        end else begin
            lowCnt_q <= transceiverResetN ? 16'h0 : lowCnt_q + 16'h1;
            wasHigh_q <= wasHigh_q | transceiverResetN;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    chk_read_slot: assert property (!$past(regRdEn) |-> regRdData == 32'h0)
        else $error("read data outside its slot");
    chk_state_legal: assert property (powerState != PM_RESV)
        else $error("reserved power state");
    chk_sleep_unready: assert property (powerState != PM_NORMAL |-> !deviceReady)
        else $error("ready while asleep");
    chk_sleep_entry: assert property ($fell(deviceReady) |-> $past(regWrEn)
        && $past(regAddr) == PMC_OFFSET && powerState != PM_NORMAL)
        else $error("ready dropped without sleep write");
    chk_wake_settle: assert property (wakeWr && powerState != PM_NORMAL
        |-> !deviceReady [*8] ##[10:11] (deviceReady && powerState == PM_NORMAL))
        else $error("wake did not settle in time");
    chk_xcvr_start: assert property ($fell(transceiverResetN) |-> $past(rstWr, 2))
        else $error("transceiver reset without write");
    chk_xcvr_len: assert property ($rose(transceiverResetN) && wasHigh_q
        |-> lowCnt_q == TRANSCEIVER_RESET_CYCLES)
        else $error("transceiver reset length wrong");
    chk_intr_cause: assert property ($rose(wakeInterrupt)
        |-> $past(lanWakeEvt) || $past(energyEvt))
        else $error("interrupt without event");
    chk_intr_clear: assert property ($fell(wakeInterrupt) |-> $past(regWrEn))
        else $error("interrupt dropped without write");
endmodule // pmwc_power_ctrl_asserts
bind pmwc_power_ctrl pmwc_power_ctrl_asserts #(.TRANSCEIVER_RESET_CYCLES(TRANSCEIVER_RESET_CYCLES))
    pmwc_power_ctrl_asserts_i (.sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .lanWakeEvt(lanWakeEvt), .energyEvt(energyEvt), .powerState(powerState),
    .deviceReady(deviceReady), .wakeInterrupt(wakeInterrupt),
    .transceiverResetN(transceiverResetN));

// >>> pmwc_power_ctrl_tb.sv
/* pmwc_power_ctrl_tb: self-checking bench of the power-mode block.
   assumes the host model and the bound checker; counts are shortened. */
`timescale 1ns/1ps
`define CHK(g, x) begin n_tests++; if ((g) !== (x)) begin n_mismatch++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, x); end end
module pmwc_power_ctrl_tb import pmwc_pkg::*; ;
    localparam int RST_N = 20;
    localparam int PLS_N = 30;
    logic sys_clk, resetn, lanWakeEvt, energyEvt, regWrEn, regRdEn;
    logic deviceReady, wakeInterrupt, transceiverResetN, wakeOut, wakeOutOe;
    logic [7:0] regAddr;
    logic [31:0] regWrData, regRdData, e, m, w;
    logic [1:0] powerState, sel;
    logic rdSeen = 1'b0;
    int n_mismatch = 0;
    int n_tests = 0;
    bit ok;
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    pmwc_power_ctrl #(.TRANSCEIVER_RESET_CYCLES(RST_N), .PULSE_CYCLES(PLS_N)) pmwc_power_ctrl_i (
        .sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
        .lanWakeEvt(lanWakeEvt), .energyEvt(energyEvt), .powerState(powerState),
        .deviceReady(deviceReady), .wakeInterrupt(wakeInterrupt),
        .transceiverResetN(transceiverResetN), .wakeOut(wakeOut), .wakeOutOe(wakeOutOe));
    pmwc_host pmwc_host_i (.clk(sys_clk), .ready(deviceReady), .addr(regAddr),
        .wrData(regWrData), .wrEn(regWrEn), .rdEn(regRdEn));
    always @(posedge sys_clk) begin
        if (rdSeen) begin
            e = pmwc_host_i.expQ.pop_front();
            m = pmwc_host_i.mskQ.pop_front();
            `CHK(regRdData & m, e)
        end
        rdSeen <= regRdEn;
    end
    // open-drain pulls low when active, push-pull follows polarity
    task automatic pin(input logic act, pp, pol);
        `CHK({wakeOutOe, wakeOut}, pp ? {1'b1, act ~^ pol} : {act, 1'b0})
    endtask
    task automatic results;
        $display("mismatches %0d tests %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        results();
    end
    initial begin
        void'($urandom(32'hb4b85ac3));
        resetn = 1'b0;
        lanWakeEvt = 1'b0;
        energyEvt = 1'b0;
        repeat (16) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        pmwc_host_i.wr(PMC_OFFSET, 32'h302);
        pmwc_host_i.rd(PMC_OFFSET, 32'h1, 32'hffffffff);
        pmwc_host_i.rd(TEST_OFFSET, TEST_PATTERN, 32'hffffffff);
        pmwc_host_i.rd(8'h10, 32'h0, 32'hffffffff);
        pmwc_host_i.wr(PMC_OFFSET, 32'h400);
        pmwc_host_i.rd(PMC_OFFSET, 32'h400, 32'h400);
        pmwc_host_i.wr(PMC_OFFSET, 32'h400);
        // read lands after the first span ends but before a retriggered one would
        repeat (RST_N - 4) @(posedge sys_clk);
        pmwc_host_i.rd(PMC_OFFSET, 32'h0, 32'h400);
        `CHK(transceiverResetN, 1'b1)
        for (int i = 0; i < 16; i++) begin
            w = 32'h300 | (i[0] << 6) | (i[1] << 2) | (i[2] << 1) | (i[3] << 3);
            sel = 2'(i % 3 + 1);
            pmwc_host_i.wr(PMC_OFFSET, w);
            repeat (2) @(posedge sys_clk);
            pin(1'b0, i[0], i[1]);
            energyEvt <= sel[0];
            lanWakeEvt <= sel[1];
            // the pulsed request runs one cycle behind the static one
            repeat (4) @(posedge sys_clk);
            pin(i[2], i[0], i[1]);
            `CHK(wakeInterrupt, 1'b1)
            pmwc_host_i.rd(PMC_OFFSET, {26'h0, sel, 4'h0}, 32'h30);
            repeat (PLS_N - 4) @(posedge sys_clk);
            pin(i[2], i[0], i[1]);
            repeat (4) @(posedge sys_clk);
            pin(i[2] & ~i[3], i[0], i[1]);
            energyEvt <= 1'b0;
            lanWakeEvt <= 1'b0;
            pmwc_host_i.wr(PMC_OFFSET, w | 32'h30);
            repeat (2) @(posedge sys_clk);
            `CHK(wakeInterrupt, 1'b0)
            pin(1'b0, i[0], i[1]);
        end
        pmwc_host_i.wr(PMC_OFFSET, 32'h100);
        lanWakeEvt <= 1'b1;
        repeat (3) @(posedge sys_clk);
        `CHK(wakeInterrupt, 1'b0)
        lanWakeEvt <= 1'b0;
        for (int k = 1; k < 3; k++) begin
            pmwc_host_i.wr(PMC_OFFSET, 32'h300 | (k << 12));
            repeat (2) @(posedge sys_clk);
            `CHK({powerState, deviceReady}, {k[1:0], 1'b0})
            pmwc_host_i.rd(PMC_OFFSET, k << 12, 32'h3001);
            pmwc_host_i.wake(ok);
            `CHK(ok, 1'b1)
        end
        results();
    end
endmodule // pmwc_power_ctrl_tb
